// ===== rtl/tpsl_core.v
// Trigger compare, period generator, event routing and stamp queue
// Assumes one AHB-Lite master, a 10 MHz mclk and synchronous reset
//
// Notes on behaviour
// - First trigger match starts the armed generator; it then runs freely.
// - Full output period is twice the programmed half-period.
// - Compare holds ns low, seconds [19:0] and firing level [21:20] high.
// - Control 0x00018054 sets trigger, generator, output, low start, armed start.
// - Control 0x00018055 adds stamp capture on event input zero.
// - At firing the output shows the initial level without an edge.
// - First toggle falls within half-period plus one step; low start rises.
// - Later toggles scheduled from exact time, lateness never accumulates.
// - Trigger fires within one step after the compare time.
// - Routing register loops trigger or period output to event input.
// - Routing resets to 0x00430059; 0x00450059 loops period to event input.
// - Event input passes three sync stages before stamping.
// - Only rising edges of the event input are stamped.
// - Stamp reads at 0x0a4 low and 0x0a8 high, low first.
// - Trigger fires only when time is at or past the compare time.
// - Event input zero queues up to sixteen stamps.
// - Reading an empty queue returns a zero pair.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "tpsl_map.vh"

module tpsl_core (
	// Clock and reset
	input wire mclk,
	input wire reset,
	input wire ce,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	// Event pins
	input wire captureInZero,
	output reg compareOutZero,
	output reg squareOutZero
);

	localparam P_IDLE = 3'b001;
	localparam P_WAIT = 3'b010;
	localparam P_RUN = 3'b100;

	// Seconds and nanoseconds to linear fixed-point time
	function [63:0] toLinear;
		input [19:0] sec;
		input [31:0] ns;
		reg [63:0] tmp;
		begin
			tmp = {44'h0, sec} * {32'h0, `TPSL_NS_PER_SEC} + {32'h0, ns};
			toLinear = {tmp[47:0], 16'h0000};
		end
	endfunction

	// Event source selection
	function srcLevel;
		input [3:0] sel;
		input pin;
		input trig;
		input per;
		begin
			case (sel)
				`TPSL_SRC_TRIG: srcLevel = trig;
				`TPSL_SRC_PERIOD: srcLevel = per;
				default: srcLevel = pin;
			endcase
		end
	endfunction

	// Hardware time
	reg [31:0] timeSec;
	reg [31:0] timeNs;
	reg [63:0] linTime;
	// Registers
	reg [31:0] ctrl;
	reg [31:0] route;
	reg [31:0] trigLow;
	reg [63:0] trigCmp;
	reg trigArmed;
	reg [31:0] halfLow;
	reg [63:0] halfPeriod;
	reg [31:0] timeHold;
	reg [31:0] stampHold;
	// Bus state
	reg busPend;
	reg busWrite;
	reg busInRange;
	reg [11:0] busAddr;
	// Period generator
	reg [2:0] perState;
	reg perLevel;
	reg [63:0] nextEdge;
	reg [2:0] next_perState;
	reg next_perLevel;
	reg [63:0] next_nextEdge;
	// Event path
	reg [`TPSL_SYNC_STAGES-1:0] evSync;
	reg evPrev;
	reg [`TPSL_FIFO_AW-1:0] wrPtr;
	reg [`TPSL_FIFO_AW-1:0] rdPtr;
	reg [4:0] fifoCount;
	reg headOk;
	wire [`TPSL_STAMP_W-1:0] headData;
	reg [31:0] readValue;

	wire accept = hsel & htrans[1] & hready & hreadyout;
	wire doWrite = busPend & busWrite & busInRange;
	wire doRead = busPend & ~busWrite & busInRange;
	wire trigFire;
	wire stampPush;
	wire stampPop;
	wire [63:0] cmpLin = toLinear(trigCmp[51:32], trigCmp[31:0]);
	wire nsWrap = (timeNs + `TPSL_CLK_PERIOD_NS) >= `TPSL_NS_PER_SEC;
	wire evLevel = srcLevel(route[`TPSL_SRC_MSB:`TPSL_SRC_LSB], captureInZero,
		compareOutZero, squareOutZero);

	assign trigFire = ctrl[`TPSL_CTL_TRIG] & trigArmed &
		({timeSec, timeNs} >= {12'h000, trigCmp[51:32], trigCmp[31:0]});
	assign stampPush = ctrl[`TPSL_CTL_EVENT] & evSync[`TPSL_SYNC_STAGES-1] & ~evPrev &
		(fifoCount != `TPSL_FIFO_DEPTH);
	assign stampPop = doRead & (busAddr == `TPSL_OFS_STAMP_LO) & headOk;

	// Read multiplexer
	always @* begin
		readValue = 32'h00000000;
		case (busAddr)
			`TPSL_OFS_CTRL: readValue = ctrl;
			`TPSL_OFS_STAMP_LO: readValue = headOk ? headData[31:0] : 32'h00000000;
			`TPSL_OFS_STAMP_HI: readValue = stampHold;
			`TPSL_OFS_TIME_LO: readValue = timeNs;
			`TPSL_OFS_TIME_HI: readValue = timeHold;
			`TPSL_OFS_TRIG_LO: readValue = trigLow;
			`TPSL_OFS_TRIG_HI: readValue = trigCmp[63:32];
			`TPSL_OFS_HALF_LO: readValue = halfLow;
			`TPSL_OFS_HALF_HI: readValue = halfPeriod[63:32];
			`TPSL_OFS_ROUTE: readValue = route;
			default: readValue = 32'h00000000;
		endcase
	end

	// Period generator next state
	always @* begin
		next_perState = perState;
		next_perLevel = perLevel;
		next_nextEdge = nextEdge;
		case (perState)
			P_IDLE: begin
				next_perLevel = ctrl[`TPSL_CTL_PER_FORCE];
				if (ctrl[`TPSL_CTL_PER_EN]) begin
					next_perLevel = ctrl[`TPSL_CTL_PER_INIT];
					if (ctrl[`TPSL_CTL_TRIG_START]) begin
						next_perState = P_WAIT;
					end else begin
						next_perState = P_RUN;
						next_nextEdge = linTime + halfPeriod;
					end
				end
			end
			P_WAIT: begin
				if (trigFire) begin
					next_perState = P_RUN;
					next_nextEdge = cmpLin + halfPeriod;
				end
			end
			P_RUN: begin
				if (linTime >= nextEdge) begin
					next_perLevel = ~perLevel;
					next_nextEdge = nextEdge + halfPeriod;
				end
			end
			default: next_perState = P_IDLE;
		endcase
		if (!ctrl[`TPSL_CTL_PER_EN]) begin
			next_perState = P_IDLE;
			next_perLevel = ctrl[`TPSL_CTL_PER_FORCE];
		end
	end

	// Time base and period generator state
	always @(posedge mclk) begin
		if (reset) begin
			timeSec <= 32'h00000000;
			timeNs <= 32'h00000000;
			linTime <= 64'h0000000000000000;
			perState <= P_IDLE;
			perLevel <= 1'b0;
			nextEdge <= 64'h0000000000000000;
			squareOutZero <= 1'b0;
		end else if (ce) begin
			linTime <= linTime + `TPSL_STEP_LIN;
			if (nsWrap) begin
				timeNs <= timeNs + `TPSL_CLK_PERIOD_NS - `TPSL_NS_PER_SEC;
				timeSec <= timeSec + 32'h00000001;
			end else begin
				timeNs <= timeNs + `TPSL_CLK_PERIOD_NS;
			end
			perState <= next_perState;
			perLevel <= next_perLevel;
			nextEdge <= next_nextEdge;
			squareOutZero <= next_perLevel & ctrl[`TPSL_CTL_PER_OE];
		end
	end

	// Trigger output
	always @(posedge mclk) begin
		if (reset) begin
			compareOutZero <= 1'b0;
		end else if (ce) begin
			if (trigFire) begin
				case (trigCmp[`TPSL_TRIG_LVL_MSB+32:`TPSL_TRIG_LVL_LSB+32])
					`TPSL_LVL_LOW: compareOutZero <= 1'b0;
					`TPSL_LVL_HIGH: compareOutZero <= 1'b1;
					default: compareOutZero <= ~compareOutZero;
				endcase
			end
		end
	end

	// AHB-Lite slave and registers
	always @(posedge mclk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			busPend <= 1'b0;
			busWrite <= 1'b0;
			busInRange <= 1'b0;
			busAddr <= 12'h000;
			ctrl <= `TPSL_CTRL_RESET;
			route <= `TPSL_ROUTE_RESET;
			trigLow <= 32'h00000000;
			trigCmp <= 64'h0000000000000000;
			trigArmed <= 1'b0;
			halfLow <= 32'h00000000;
			halfPeriod <= 64'h0000000000000000;
			timeHold <= 32'h00000000;
			stampHold <= 32'h00000000;
		end else if (ce) begin
			busPend <= accept;
			if (accept) begin
				hreadyout <= 1'b0;
				busWrite <= hwrite;
				busAddr <= {haddr[11:2], 2'b00};
				busInRange <= (haddr[31:12] == 20'h00000) & (haddr[1:0] == 2'b00) &
					(hsize == 3'b010);
			end else if (busPend) begin
				hreadyout <= 1'b1;
				hrdata <= doRead ? readValue : 32'h00000000;
			end
			if (trigFire) begin
				trigArmed <= 1'b0;
			end
			if (doWrite) begin
				case (busAddr)
					`TPSL_OFS_CTRL: ctrl <= hwdata;
					`TPSL_OFS_TRIG_LO: trigLow <= hwdata;
					`TPSL_OFS_TRIG_HI: begin
						trigCmp <= {hwdata, trigLow};
						trigArmed <= 1'b1;
					end
					`TPSL_OFS_HALF_LO: halfLow <= hwdata;
					`TPSL_OFS_HALF_HI: halfPeriod <= {hwdata, halfLow};
					`TPSL_OFS_ROUTE: route <= hwdata;
					default: ctrl <= ctrl;
				endcase
			end
			if (doRead && busAddr == `TPSL_OFS_STAMP_LO) begin
				stampHold <= headOk ? headData[63:32] : 32'h00000000;
			end
			if (doRead && busAddr == `TPSL_OFS_TIME_LO) begin
				timeHold <= timeSec;
			end
		end
	end

	// Event synchroniser and stamp queue pointers
	always @(posedge mclk) begin
		if (reset) begin
			evSync <= {`TPSL_SYNC_STAGES{1'b0}};
			evPrev <= 1'b0;
			wrPtr <= {`TPSL_FIFO_AW{1'b0}};
			rdPtr <= {`TPSL_FIFO_AW{1'b0}};
			fifoCount <= 5'h00;
			headOk <= 1'b0;
		end else if (ce) begin
			evSync <= {evSync[`TPSL_SYNC_STAGES-2:0], evLevel};
			evPrev <= evSync[`TPSL_SYNC_STAGES-1];
			if (stampPush) begin
				wrPtr <= wrPtr + 4'h1;
			end
			if (stampPop) begin
				rdPtr <= rdPtr + 4'h1;
			end
			if (stampPush && !stampPop) begin
				fifoCount <= fifoCount + 5'h01;
			end else if (stampPop && !stampPush) begin
				fifoCount <= fifoCount - 5'h01;
			end
			headOk <= (fifoCount != 5'h00) & ~stampPop;
		end
	end

	tpsl_stamp_mem stampStore (
		.mclk(mclk),
		.ce(ce),
		.wrEn(stampPush),
		.wrAddr(wrPtr),
		.wrData({timeSec, timeNs}),
		.rdAddr(rdPtr),
		.rdData(headData)
	);

endmodule

// ===== rtl/tpsl_map.vh
// Register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz mclk and word-aligned AHB-Lite byte addresses
`ifndef TPSL_MAP_VH
`define TPSL_MAP_VH

// Register byte offsets
`define TPSL_OFS_CTRL 12'h04c
`define TPSL_OFS_STAMP_LO 12'h0a4
`define TPSL_OFS_STAMP_HI 12'h0a8
`define TPSL_OFS_TIME_LO 12'h0c0
`define TPSL_OFS_TIME_HI 12'h0c4
`define TPSL_OFS_TRIG_LO 12'h0d0
`define TPSL_OFS_TRIG_HI 12'h0d4
`define TPSL_OFS_HALF_LO 12'h0f0
`define TPSL_OFS_HALF_HI 12'h0f4
`define TPSL_OFS_ROUTE 12'h200

// Reset values
`define TPSL_CTRL_RESET 32'h00000000
`define TPSL_ROUTE_RESET 32'h00430059

// Control bit positions
`define TPSL_CTL_EVENT 0
`define TPSL_CTL_TRIG 2
`define TPSL_CTL_PER_EN 4
`define TPSL_CTL_PER_OE 6
`define TPSL_CTL_PER_INIT 8
`define TPSL_CTL_PER_FORCE 9
`define TPSL_CTL_TRIG_OE 15
`define TPSL_CTL_TRIG_START 16

// Trigger compare upper word fields
`define TPSL_TRIG_SEC_MSB 19
`define TPSL_TRIG_LVL_LSB 20
`define TPSL_TRIG_LVL_MSB 21
`define TPSL_LVL_LOW 2'h0
`define TPSL_LVL_HIGH 2'h1

// Event source field of the routing register
`define TPSL_SRC_LSB 16
`define TPSL_SRC_MSB 19
`define TPSL_SRC_PIN 4'h3
`define TPSL_SRC_TRIG 4'h4
`define TPSL_SRC_PERIOD 4'h5

// Time base
`define TPSL_CLK_PERIOD_NS 32'h00000064
`define TPSL_NS_PER_SEC 32'h3b9aca00
`define TPSL_FRAC_BITS 16
`define TPSL_STEP_LIN ({32'h00000000, `TPSL_CLK_PERIOD_NS} << `TPSL_FRAC_BITS)
`define TPSL_SYNC_STAGES 3

// Stamp queue
`define TPSL_FIFO_DEPTH 5'h10
`define TPSL_FIFO_AW 4
`define TPSL_STAMP_W 64

`endif

// ===== rtl/tpsl_stamp_mem.v
// Sixteen-entry timestamp store with registered read data
// Assumes the owner keeps pointers and never writes a full queue
`timescale 1ns/1ps
`include "tpsl_map.vh"

module tpsl_stamp_mem (
	// Clock
	input wire mclk,
	input wire ce,
	// Write side
	input wire wrEn,
	input wire [`TPSL_FIFO_AW-1:0] wrAddr,
	input wire [`TPSL_STAMP_W-1:0] wrData,
	// Read side
	input wire [`TPSL_FIFO_AW-1:0] rdAddr,
	output reg [`TPSL_STAMP_W-1:0] rdData
);

	reg [`TPSL_STAMP_W-1:0] store [0:15];

	always @(posedge mclk) begin
		if (ce) begin
			if (wrEn) begin
				store[wrAddr] <= wrData;
			end
			rdData <= store[rdAddr];
		end
	end

endmodule

// ===== sim/tpsl_core_properties.sv
// Concurrent checks on bus handshake, trigger and square output pins
// Bound to tpsl_core; assumes ce high and a ten-cycle half period
`timescale 1ns/1ps
module tpsl_props (
	// Clock and reset
	input wire mclk,
	input wire reset,
	input wire ce,
	// Bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Pins
	input wire compareOutZero,
	input wire squareOutZero
);
	logic acc;
	logic sqSeen;
	assign acc = hsel && htrans[1] && hready && hreadyout && ce;
	always @(posedge mclk) begin
		if (reset)
			sqSeen <= 1'b0;
		else if (squareOutZero)
			sqSeen <= 1'b1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	AST_WAIT_STATE: assert property (acc |=> !hreadyout ##1 hreadyout)
		else $error("transfer not two cycles");
	AST_READY_IDLE: assert property (hreadyout && !acc |=> hreadyout)
		else $error("ready dropped while idle");
	AST_RDATA_HOLD: assert property (hreadyout && !acc |=> $stable(hrdata))
		else $error("read data moved while idle");
	AST_ARMED_WAIT: assert property (!sqSeen && !compareOutZero |-> !squareOutZero)
		else $error("square ran before trigger");
	AST_FIRE_LEVEL: assert property ($rose(compareOutZero) && !sqSeen |-> $stable(squareOutZero))
		else $error("edge at trigger fire");
	AST_FIRST_TOGGLE: assert property ($rose(compareOutZero) && !sqSeen
		|-> !squareOutZero[*8] ##1 !squareOutZero ##[1:3] squareOutZero)
		else $error("first toggle off time");
	AST_HIGH_HALF: assert property ($rose(squareOutZero)
		|-> squareOutZero[*8] ##1 squareOutZero[*2] ##1 !squareOutZero)
		else $error("high half wrong");
	AST_LOW_HALF: assert property ($fell(squareOutZero)
		|-> !squareOutZero[*8] ##1 !squareOutZero[*2] ##1 squareOutZero)
		else $error("low half wrong");
	cover property (acc && !hwrite);
	cover property ($rose(compareOutZero));
	cover property ($fell(squareOutZero));
endmodule

// ===== sim/tb_tpsl_core.sv
// Bench for trigger-started square output looped to the stamp queue
// Drives AHB-Lite directly at 10 MHz; reads scored from a queue
`timescale 1ns/1ps
module tb_tpsl_core;
	localparam logic [31:0] TRIG_NS = 32'h00004e20;
	logic mclk = 0;
	logic reset = 1;
	logic hsel = 0;
	logic hwrite = 0;
	logic capIn = 0;
	logic pend = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] r;
	logic [31:0] eLo;
	logic [31:0] eHi;
	logic [31:0] qLo[$];
	logic [31:0] qHi[$];
	wire hreadyout;
	wire hresp;
	wire compareOutZero;
	wire squareOutZero;
	wire [31:0] hrdata;
	int fail_count = 0;
	int n_tests = 0;
	always #50 mclk = ~mclk;
	tpsl_core dut (.mclk(mclk), .reset(reset), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.captureInZero(capIn), .compareOutZero(compareOutZero),
		.squareOutZero(squareOutZero));
	task check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, lo, hi);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(negedge mclk); while (!hreadyout);
		@(posedge mclk);
		hsel <= 0;
		htrans <= 0;
		hwdata <= d;
		if (!w) begin
			qLo.push_back(lo);
			qHi.push_back(hi);
		end
		do @(negedge mclk); while (!hreadyout);
		@(posedge mclk);
	endtask
	// Read scoreboard and random pin noise
	always @(posedge mclk) begin
		capIn <= 1'($urandom);
		if (pend && hreadyout) begin
			eLo = qLo.pop_front();
			eHi = qHi.pop_front();
			if (eLo == eHi)
				check(hrdata, eLo);
			else
				check({31'h0, hrdata >= eLo && hrdata <= eHi}, 1);
		end
		// Read stays pending until its data phase completes
		if (hsel && htrans[1] && hreadyout && !hwrite)
			pend <= 1;
		else if (hreadyout)
			pend <= 0;
	end
	initial begin
		#500000;
		fail_count++;
		complete_run;
	end
	initial begin
		void'($urandom(71808));
		repeat (6) @(posedge mclk);
		reset <= 0;
		@(posedge mclk);
		bus(0, 12'h200, 0, 32'h00430059, 32'h00430059);
		bus(0, 12'h0a4, 0, 0, 0);
		bus(0, 12'h0a8, 0, 0, 0);
		bus(0, 12'h0fc, 0, 0, 0);
		$display("done: reset values");
		repeat (2) begin
			r = $urandom;
			bus(1, 12'h0f0, r, 0, 0);
			bus(1, 12'h0f4, ~r, 0, 0);
			bus(0, 12'h0f0, 0, r, r);
			bus(0, 12'h0f4, 0, ~r, ~r);
		end
		bus(1, 12'h200, 32'h00450059, 0, 0);
		bus(0, 12'h200, 0, 32'h00450059, 32'h00450059);
		$display("done: register access");
		bus(1, 12'h0f0, 32'h03e80000, 0, 0);
		bus(1, 12'h0f4, 0, 0, 0);
		bus(1, 12'h04c, 32'h00000004, 0, 0);
		bus(1, 12'h0d0, TRIG_NS, 0, 0);
		bus(1, 12'h0d4, 32'h00100000, 0, 0);
		bus(1, 12'h04c, 32'h00018055, 0, 0);
		repeat (400) if (!compareOutZero) @(posedge mclk);
		check(compareOutZero, 1);
		repeat (30) @(posedge mclk);
		for (int k = 0; k < 2; k++) begin
			bus(1, 12'h0d4, {10'h0, k ? 2'h2 : 2'h0, 20'h0}, 0, 0);
			repeat (3) @(posedge mclk);
			check(compareOutZero, k);
		end
		$display("done: trigger start");
		repeat (340) @(posedge mclk);
		bus(1, 12'h04c, 32'h00018054, 0, 0);
		for (int k = 0; k < 16; k++) begin
			r = TRIG_NS + (2 * k + 1) * 1000;
			bus(0, 12'h0a4, 0, r, r + 700);
			bus(0, 12'h0a8, 0, 0, 0);
		end
		bus(0, 12'h0a4, 0, 0, 0);
		bus(0, 12'h0a8, 0, 0, 0);
		repeat (2) @(posedge mclk);
		$display("done: stamp queue");
		// Stop at the start of the low half, force low, then restart high at once without trigger start
		@(negedge squareOutZero);
		@(posedge mclk);
		bus(1, 12'h04c, 32'h00018044, 0, 0);
		bus(1, 12'h04c, 32'h00000040, 0, 0);
		check(squareOutZero, 0);
		bus(1, 12'h04c, 32'h00000150, 0, 0);
		@(posedge mclk);
		check(squareOutZero, 1);
		$display("done: restart");
		complete_run;
	end
endmodule
bind tpsl_core tpsl_props chk (.mclk(mclk), .reset(reset), .ce(ce), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .compareOutZero(compareOutZero),
	.squareOutZero(squareOutZero));
